// [inc/fidsr_map.svh]
`ifndef FIDSR_MAP_SVH
`define FIDSR_MAP_SVH
// Opcodes
`define FIDSR_OP_JEDEC_ID   8'h9f
`define FIDSR_OP_SFDP       8'h5a
`define FIDSR_OP_SEC_ERASE  8'h44
`define FIDSR_OP_SEC_PROG   8'h42
`define FIDSR_OP_SEC_READ   8'h48
`define FIDSR_OP_SET_PARAM  8'hc0
`define FIDSR_OP_SET_WRAP   8'h77
`define FIDSR_OP_ENTER_4W   8'h38
`define FIDSR_OP_EXIT_4W    8'hff
`define FIDSR_OP_WREN       8'h06
`define FIDSR_OP_WRDI       8'h04
`define FIDSR_OP_STATUS     8'h05
`define FIDSR_OP_RST_EN     8'h66
`define FIDSR_OP_RST        8'h99
// Frame bit positions
`define FIDSR_HDR_CMD       12'h008
`define FIDSR_HDR_ADDR      12'h020
`define FIDSR_HDR_DUMMY     12'h028
`define FIDSR_ADDR_BITS     12'h018
`define FIDSR_DUMMY_BITS    12'h008
`define FIDSR_BIT_OP_LAST   12'h007
`define FIDSR_BIT_ADDR_LAST 12'h01f
`define FIDSR_CNT_TOP       12'hfff
`define FIDSR_CNT_FOLD      12'h800
// Settings and values
`define FIDSR_DSEL_RST      2'h0
`define FIDSR_WSEL_RST      2'h0
`define FIDSR_DUMMY_BASE    4'h2
`define FIDSR_WRAP_BASE     7'h08
`define FIDSR_ERASED        8'hff
// Timing
`define FIDSR_CLK_MHZ       10
`define FIDSR_SEC_ERASE_US  1000
`define FIDSR_ERASE_CYC     (`FIDSR_SEC_ERASE_US * `FIDSR_CLK_MHZ)
`define FIDSR_SCK_HALF      3
`endif

// [inc/fidsr_pkg.sv]
package fidsr_pkg;
   // Host sequencer states
   typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} fidsr_hst_e;
endpackage

// [inc/fidsr_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fidsr_link_if;
   logic sck;
   logic cs_n;
   logic serial_in_pin;
   logic serial_out;
   logic serial_out_oe;
   modport host (output sck, cs_n, serial_in_pin, input serial_out, serial_out_oe);
   modport dev  (input sck, cs_n, serial_in_pin, output serial_out, serial_out_oe);
endinterface
`default_nettype wire

// [rtl/fidsr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fidsr_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
)(
   // Destination clock
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;

   if (W < 1) begin : g_bad
      $error("fidsr_sync: W must be at least 1");
   end

   // Two-stage synchroniser
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= RST;
         q_o     <= RST;
      end else begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// [rtl/fidsr_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fidsr_map.svh"
module fidsr_host
   import fidsr_pkg::*;
#(
   parameter int HALF = `FIDSR_SCK_HALF
)(
   // System
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // Link
   fidsr_link_if.host       lk,
   // Command request
   input  wire logic        cmd_valid_i,
   output logic             cmd_ready_o,
   input  wire logic [7:0]  cmd_op_i,
   input  wire logic        cmd_addr_en_i,
   input  wire logic [23:0] cmd_addr_i,
   input  wire logic        cmd_dummy_i,
   input  wire logic        cmd_write_i,
   input  wire logic [8:0]  cmd_nbytes_i,
   // Write data
   input  wire logic [7:0]  wr_byte_i,
   output logic             wr_take_o,
   // Read data and completion
   output logic [7:0]       rd_byte_o,
   output logic             rd_valid_o,
   output logic             done_o
);
   fidsr_hst_e  st_ff;
   logic [7:0]  ph_ff;
   logic [11:0] bit_ff;
   logic [11:0] tot_ff;
   logic [11:0] hdr_ff;
   logic        wr_ff;
   logic [31:0] tx_ff;
   logic [7:0]  rx_ff;
   logic        sck_ff;
   logic        cs_n_ff;
   logic        so_s;
   logic        oe_s;

   if (HALF < 3 || HALF > 255) begin : g_bad
      $error("fidsr_host: HALF must be 3..255");
   end

   // Returned data passes two flops
   fidsr_sync #(.W(2), .RST(2'h0)) u_so_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({lk.serial_out_oe, lk.serial_out}),
      .q_o      ({oe_s, so_s})
   );

   // Frame arithmetic
   wire logic [11:0] nxt_hdr = `FIDSR_HDR_CMD
                              + (cmd_addr_en_i ? `FIDSR_ADDR_BITS : 12'h000)
                              + (cmd_dummy_i ? `FIDSR_DUMMY_BITS : 12'h000);
   wire logic [11:0] nxt_tot = nxt_hdr + {cmd_nbytes_i, 3'h0};
   wire logic        so_bit  = oe_s ? so_s : 1'b1;
   wire logic [7:0]  nxt_rx  = {rx_ff[6:0], so_bit};
   wire logic [11:0] dbit    = bit_ff - hdr_ff;
   wire logic [11:0] nbit    = bit_ff + 12'h001;
   wire logic [11:0] nbd     = nbit - hdr_ff;
   wire logic        rd_end  = ~wr_ff & (bit_ff >= hdr_ff) & (dbit[2:0] == 3'h7);
   wire logic        ld      = wr_ff & (nbit >= hdr_ff) & (nbd[2:0] == 3'h0);
   wire logic        last    = (bit_ff == tot_ff - 12'h001);
   wire logic        ph_end  = (ph_ff == 8'(HALF - 1));

   // Pins from flops
   assign lk.sck           = sck_ff;
   assign lk.cs_n          = cs_n_ff;
   assign lk.serial_in_pin = tx_ff[31];

   // Sequencer: shift on falling, sample on rising
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff       <= HS_IDLE;
         ph_ff       <= 8'h00;
         bit_ff      <= 12'h000;
         tot_ff      <= 12'h000;
         hdr_ff      <= 12'h000;
         wr_ff       <= 1'b0;
         tx_ff       <= 32'h0000_0000;
         rx_ff       <= 8'h00;
         sck_ff      <= 1'b0;
         cs_n_ff     <= 1'b1;
         cmd_ready_o <= 1'b1;
         wr_take_o   <= 1'b0;
         rd_byte_o   <= 8'h00;
         rd_valid_o  <= 1'b0;
         done_o      <= 1'b0;
      end else begin
         wr_take_o  <= 1'b0;
         rd_valid_o <= 1'b0;
         done_o     <= 1'b0;
         case (st_ff)
            HS_IDLE: begin
               if (cmd_valid_i) begin
                  cs_n_ff     <= 1'b0;
                  tx_ff       <= {cmd_op_i, cmd_addr_en_i ? cmd_addr_i : 24'h00_0000};
                  hdr_ff      <= nxt_hdr;
                  tot_ff      <= nxt_tot;
                  wr_ff       <= cmd_write_i;
                  bit_ff      <= 12'h000;
                  ph_ff       <= 8'h00;
                  cmd_ready_o <= 1'b0;
                  st_ff       <= HS_SHIFT;
               end
            end
            HS_SHIFT: begin
               if (!ph_end) begin
                  ph_ff <= ph_ff + 8'h01;
               end else begin
                  ph_ff <= 8'h00;
                  if (!sck_ff) begin
                     sck_ff <= 1'b1;
                     rx_ff  <= nxt_rx;
                     if (rd_end) begin
                        rd_valid_o <= 1'b1;
                        rd_byte_o  <= nxt_rx;
                     end
                  end else begin
                     sck_ff <= 1'b0;
                     if (last) begin
                        cs_n_ff <= 1'b1;
                        st_ff   <= HS_GAP;
                     end else begin
                        bit_ff <= nbit;
                        if (ld) begin
                           tx_ff     <= {wr_byte_i, 24'h00_0000};
                           wr_take_o <= 1'b1;
                        end else begin
                           tx_ff <= {tx_ff[30:0], 1'b0};
                        end
                     end
                  end
               end
            end
            HS_GAP: begin
               if (!ph_end) begin
                  ph_ff <= ph_ff + 8'h01;
               end else begin
                  ph_ff       <= 8'h00;
                  st_ff       <= HS_IDLE;
                  cmd_ready_o <= 1'b1;
                  done_o      <= 1'b1;
               end
            end
            default: begin
               st_ff <= HS_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [rtl/fidsr_dev.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fidsr_map.svh"
// Function
// - ID read returns three bytes MSB first
// - Table read: upper address zero, low selects
// - Table data from 40th falling edge
// - Erase accepted only with write enable
// - Address selects one of three registers
// - Erase only if select rises after address
// - Busy high during erase, status readable
// - Erase completion clears write enable
// - Locked register ignores erase and program
// - Program needs write enable, ANDs data in
// - Host holds select low through program
// - Register read after eight dummy clocks
// - Read offset increments, wraps within register
// - Register read ignored while busy
// - Parameter setting only in four-wire mode
// - Bits 5:4 choose 2/4/6/8 dummies
// - Bits 1:0 choose 8/16/32/64 wrap
// - Defaults: wrap 8, dummies 2
// - Serial wrap setting kept across modes
// - Dummy setting serves four-wire reads only
// - Four-wire entry needs quad enable bit
module fidsr_dev
   import fidsr_pkg::*;
#(
   parameter int         ERASE_CYC = `FIDSR_ERASE_CYC,
   parameter logic [7:0] MFR_ID    = 8'h5c, // Arbitrary value
   parameter logic [7:0] TYPE_ID   = 8'h61, // Arbitrary value
   parameter logic [7:0] CAP_ID    = 8'h18  // Arbitrary value
)(
   // System side
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   // Link
   fidsr_link_if.dev       lk,
   // Static settings
   input  wire logic       quad_enable_bit_i,
   input  wire logic [2:0] otp_lock_bits_i,
   // Status
   output logic            busy_o,
   output logic            write_enable_latch_o,
   output logic            four_wire_command_mode_o,
   output logic [3:0]      dummy_clocks_o,
   output logic [6:0]      wrap_bytes_o
);
   // Frame state, cleared while select is high
   logic [11:0] cnt_ff;
   logic [31:0] rx_ff;
   logic [7:0]  op_ff;
   logic [23:0] addr_ff;
   logic        pgm_ok_ff;
   logic        rd_ok_ff;
   logic        so_ff;
   logic        oe_ff;
   // Settings on the link clock
   logic        wen_ff;
   logic        mode_ff;
   logic [1:0]  dsel_ff;
   logic [1:0]  wsel_ff;
   logic        rst_en_ff;
   logic        armed_ff;
   logic [1:0]  esel_ff;
   logic        done_seen_ff;
   logic [7:0]  mem [0:767];
   // System clock side
   logic        cs_prev_ff;
   logic        busy_ff;
   logic [31:0] tmr_ff;
   logic        done_tgl_ff;
   // Synchronised copies
   logic        qen_s, busy_s, done_s;
   logic [2:0]  lock_s;
   logic        cs_s, armed_s, wen_c, mode_c;
   logic [1:0]  dsel_c, wsel_c;

   if (ERASE_CYC < 1) begin : g_bad
      $error("fidsr_dev: ERASE_CYC must be at least 1");
   end

   function automatic logic sec_ok(input logic [23:0] a);
      sec_ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0)
               && (a[15:12] != 4'h0) && (a[15:12] <= 4'h3);
   endfunction

   function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
      case (a)
         8'h00:   sfdp_byte = 8'h53;
         8'h01:   sfdp_byte = 8'h46;
         8'h02:   sfdp_byte = 8'h44;
         8'h03:   sfdp_byte = 8'h50;
         default: sfdp_byte = `FIDSR_ERASED;
      endcase
   endfunction

   // Crossings into the link domain
   fidsr_sync #(.W(6), .RST(6'h00)) u_to_link (
      .clk_i    (lk.sck),
      .arst_n_i (arst_n_i),
      .d_i      ({quad_enable_bit_i, otp_lock_bits_i, busy_ff, done_tgl_ff}),
      .q_o      ({qen_s, lock_s, busy_s, done_s})
   );

   // Crossings into the system domain
   fidsr_sync #(.W(8), .RST(8'h80)) u_to_sys (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({lk.cs_n, armed_ff, wen_ff, mode_ff, dsel_ff, wsel_ff}),
      .q_o      ({cs_s, armed_s, wen_c, mode_c, dsel_c, wsel_c})
   );

   // Frame decode
   wire logic        frame_rst_n = arst_n_i & ~lk.cs_n;
   wire logic [7:0]  rx_byte  = {rx_ff[6:0], lk.serial_in_pin};
   wire logic [23:0] addr_now = {rx_ff[22:0], lk.serial_in_pin};
   wire logic        op_end   = (cnt_ff == `FIDSR_BIT_OP_LAST);
   wire logic        addr_end = (cnt_ff == `FIDSR_BIT_ADDR_LAST);
   wire logic        is_id    = (op_ff == `FIDSR_OP_JEDEC_ID);
   wire logic        is_stat  = (op_ff == `FIDSR_OP_STATUS);
   wire logic        is_sfdp  = (op_ff == `FIDSR_OP_SFDP);
   wire logic        is_srd   = (op_ff == `FIDSR_OP_SEC_READ);
   wire logic        is_prog  = (op_ff == `FIDSR_OP_SEC_PROG);
   wire logic        is_ers   = (op_ff == `FIDSR_OP_SEC_ERASE);
   wire logic        is_wrap  = (op_ff == `FIDSR_OP_SET_WRAP);
   wire logic        is_prm   = (op_ff == `FIDSR_OP_SET_PARAM);
   wire logic [11:0] hdr_len  = (is_sfdp | is_srd) ? `FIDSR_HDR_DUMMY
                              : is_prog ? `FIDSR_HDR_ADDR : `FIDSR_HDR_CMD;
   wire logic        in_data  = (cnt_ff >= hdr_len);
   wire logic [11:0] dpos     = cnt_ff - hdr_len;
   wire logic [7:0]  didx     = dpos[10:3];
   wire logic        byte_done = in_data & (dpos[2:0] == 3'h7);
   wire logic [11:0] nxt_cnt  = (cnt_ff == `FIDSR_CNT_TOP) ? `FIDSR_CNT_FOLD
                              : cnt_ff + 12'h001;
   wire logic        sec_now  = sec_ok(addr_now);
   wire logic [1:0]  rsel_now = addr_now[13:12] - 2'h1;
   wire logic        wr_ok_now = wen_ff & sec_now & ~lock_s[rsel_now] & ~busy_s;
   wire logic        ers_acc  = addr_end & is_ers & wr_ok_now;
   wire logic        erase_now = done_s ^ done_seen_ff;
   wire logic        op_wren  = op_end & (rx_byte == `FIDSR_OP_WREN);
   wire logic        op_rst   = op_end & (rx_byte == `FIDSR_OP_RST) & rst_en_ff;
   wire logic        wen_clr  = erase_now | (op_end & (rx_byte == `FIDSR_OP_WRDI))
                              | (addr_end & is_prog & wr_ok_now);
   wire logic [9:0]  mem_a    = {addr_ff[13:12] - 2'h1, addr_ff[7:0] + didx};
   wire logic [7:0]  id_byte  = (didx == 8'h00) ? MFR_ID
                              : (didx == 8'h01) ? TYPE_ID
                              : (didx == 8'h02) ? CAP_ID : 8'h00;
   wire logic [7:0]  tx_byte  = is_id ? id_byte
                              : is_stat ? {6'h00, wen_ff, busy_s}
                              : is_sfdp ? sfdp_byte(addr_ff[7:0] + didx)
                              : mem[mem_a];
   wire logic        drive_en = in_data & (is_id | is_stat | ((is_sfdp | is_srd) & rd_ok_ff));
   wire logic        start    = cs_s & ~cs_prev_ff & armed_s & ~busy_ff;

   assign lk.serial_out    = so_ff;
   assign lk.serial_out_oe = oe_ff;
   assign busy_o           = busy_ff;

   // Shift in opcode and address
   always_ff @(posedge lk.sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_ff    <= 12'h000;
         rx_ff     <= 32'h0000_0000;
         op_ff     <= 8'h00;
         addr_ff   <= 24'h00_0000;
         pgm_ok_ff <= 1'b0;
         rd_ok_ff  <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         rx_ff  <= {rx_ff[30:0], lk.serial_in_pin};
         if (op_end) begin
            op_ff <= rx_byte;
         end
         if (addr_end) begin
            addr_ff   <= addr_now;
            pgm_ok_ff <= is_prog & wr_ok_now;
            rd_ok_ff  <= is_sfdp ? (addr_now[23:8] == 16'h0000)
                                 : sec_now & ~busy_s;
         end
      end
   end

   // Drive data on falling edges, MSB first
   always_ff @(negedge lk.sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         so_ff <= drive_en & tx_byte[3'h7 - dpos[2:0]];
         oe_ff <= drive_en;
      end
   end

   // Write enable, mode and read settings
   always_ff @(posedge lk.sck or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wen_ff       <= 1'b0;
         mode_ff      <= 1'b0;
         dsel_ff      <= `FIDSR_DSEL_RST;
         wsel_ff      <= `FIDSR_WSEL_RST;
         rst_en_ff    <= 1'b0;
         armed_ff     <= 1'b0;
         esel_ff      <= 2'h0;
         done_seen_ff <= 1'b0;
      end else begin
         done_seen_ff <= done_s;
         armed_ff     <= ers_acc;
         if (ers_acc) begin
            esel_ff <= rsel_now;
         end
         if (op_end) begin
            rst_en_ff <= (rx_byte == `FIDSR_OP_RST_EN);
         end
         if (op_rst) begin
            wen_ff  <= 1'b0;
            mode_ff <= 1'b0;
            dsel_ff <= `FIDSR_DSEL_RST;
            wsel_ff <= `FIDSR_WSEL_RST;
         end else begin
            if (op_wren) begin
               wen_ff <= 1'b1;
            end else if (wen_clr) begin
               wen_ff <= 1'b0;
            end
            if (op_end & (rx_byte == `FIDSR_OP_ENTER_4W) & ~mode_ff & qen_s) begin
               mode_ff <= 1'b1;
            end else if (op_end & (rx_byte == `FIDSR_OP_EXIT_4W) & mode_ff) begin
               mode_ff <= 1'b0;
            end
            if (byte_done & (didx == 8'h00) & is_wrap & ~mode_ff) begin
               wsel_ff <= rx_byte[5:4];
            end
            if (byte_done & (didx == 8'h00) & is_prm & mode_ff) begin
               dsel_ff <= rx_byte[5:4];
               wsel_ff <= rx_byte[1:0];
            end
         end
      end
   end

   // Register array: erase fills, program clears bits
   always_ff @(posedge lk.sck) begin
      if (erase_now) begin
         for (int i = 0; i < 256; i++) begin
            mem[{esel_ff, 8'(i)}] <= `FIDSR_ERASED;
         end
      end else if (byte_done & is_prog & pgm_ok_ff) begin
         mem[mem_a] <= mem[mem_a] & rx_byte;
      end
   end

   // Self-timed erase and status outputs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_prev_ff               <= 1'b1;
         busy_ff                  <= 1'b0;
         tmr_ff                   <= 32'h0000_0000;
         done_tgl_ff              <= 1'b0;
         write_enable_latch_o     <= 1'b0;
         four_wire_command_mode_o <= 1'b0;
         dummy_clocks_o           <= `FIDSR_DUMMY_BASE;
         wrap_bytes_o             <= `FIDSR_WRAP_BASE;
      end else begin
         cs_prev_ff <= cs_s;
         if (start) begin
            busy_ff <= 1'b1;
            tmr_ff  <= 32'h0000_0000;
         end else if (busy_ff) begin
            if (tmr_ff == 32'(ERASE_CYC - 1)) begin
               busy_ff     <= 1'b0;
               done_tgl_ff <= ~done_tgl_ff;
            end else begin
               tmr_ff <= tmr_ff + 32'h0000_0001;
            end
         end
         write_enable_latch_o     <= wen_c;
         four_wire_command_mode_o <= mode_c;
         dummy_clocks_o           <= `FIDSR_DUMMY_BASE + {1'b0, dsel_c, 1'b0};
         wrap_bytes_o             <= `FIDSR_WRAP_BASE << wsel_c;
      end
   end
endmodule
`default_nettype wire

// [verif/fidsr_link_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module fidsr_link_properties (
   // System clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Link
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic serial_in_pin_i,
   input wire logic serial_out_i,
   input wire logic serial_out_oe_i
);
   logic       sck_q_ff;
   logic [7:0] bits_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Rising link clock edges within a frame
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_q_ff <= 1'b0;
         bits_ff  <= 8'h00;
      end else begin
         sck_q_ff <= sck_i;
         bits_ff  <= cs_n_i ? 8'h00 : bits_ff + {7'h00, sck_i & ~sck_q_ff};
      end
   end
   // Clock phases of three system cycles
   sequence hi_phase_s;
      sck_i [*3] ##1 !sck_i;
   endsequence
   sequence lo_phase_s;
      !sck_i [*3] ##1 sck_i;
   endsequence
   frame_start_a : assert property ($fell(cs_n_i) |-> lo_phase_s)
      else $error("first link clock rise not three cycles after select");
   high_phase_a : assert property ($rose(sck_i) |-> hi_phase_s)
      else $error("link clock high phase wrong length");
   low_phase_a : assert property ($fell(sck_i) && !cs_n_i |-> lo_phase_s)
      else $error("link clock low phase wrong length");
   frame_end_a : assert property ($rose(cs_n_i) |-> $fell(sck_i))
      else $error("select rose away from last clock fall");
   sck_idle_a : assert property (cs_n_i |-> !sck_i)
      else $error("link clock active outside frame");
   si_stable_a : assert property (sck_i && $past(sck_i) |-> $stable(serial_in_pin_i))
      else $error("host data moved while clock high");
   so_stable_a : assert property (sck_i && $past(sck_i) |-> $stable(serial_out_i))
      else $error("device data moved while clock high");
   oe_start_a : assert property ($rose(serial_out_oe_i) |->
      $fell(sck_i) && (bits_ff == 8'h08 || bits_ff == 8'h28))
      else $error("device output started at wrong bit");
   oe_frame_a : assert property (serial_out_oe_i |-> !cs_n_i)
      else $error("device drives outside frame");
endmodule
`default_nettype wire

// [verif/flash_id_secreg_readparam_cmds_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_id_secreg_readparam_cmds_tb;
   localparam int         ERASE = 600;
   localparam logic [7:0] MFR   = 8'h3c; // Arbitrary value
   localparam logic [7:0] TYP   = 8'h47; // Arbitrary value
   localparam logic [7:0] CAP   = 8'h19; // Arbitrary value
   logic        clk_i, arst_n_i, cmd_valid, cmd_ready, cmd_ae, cmd_dm, cmd_wr;
   logic        wr_take, rd_valid, done, quad_en, busy, wen, mode4;
   logic [7:0]  cmd_op, wr_byte, rd_byte;
   logic [23:0] cmd_addr;
   logic [8:0]  cmd_n;
   logic [2:0]  lock;
   logic [3:0]  dummy;
   logic [6:0]  wrap;
   logic [7:0]  wq[$], rq[$], mdl[256];
   logic [7:0]  idv[3] = '{MFR, TYP, CAP};
   int          fails, checks_done, cyc;
   fidsr_link_if lk ();
   fidsr_host i_fidsr_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .lk(lk.host),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op),
      .cmd_addr_en_i(cmd_ae), .cmd_addr_i(cmd_addr), .cmd_dummy_i(cmd_dm),
      .cmd_write_i(cmd_wr), .cmd_nbytes_i(cmd_n), .wr_byte_i(wr_byte), .wr_take_o(wr_take),
      .rd_byte_o(rd_byte), .rd_valid_o(rd_valid), .done_o(done));
   fidsr_dev #(.ERASE_CYC(ERASE), .MFR_ID(MFR), .TYPE_ID(TYP), .CAP_ID(CAP)) i_fidsr_dev (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .lk(lk.dev), .quad_enable_bit_i(quad_en),
      .otp_lock_bits_i(lock), .busy_o(busy), .write_enable_latch_o(wen),
      .four_wire_command_mode_o(mode4), .dummy_clocks_o(dummy), .wrap_bytes_o(wrap));
   fidsr_link_properties u_props (.clk_i(clk_i), .arst_n_i(arst_n_i), .sck_i(lk.sck),
      .cs_n_i(lk.cs_n), .serial_in_pin_i(lk.serial_in_pin), .serial_out_i(lk.serial_out),
      .serial_out_oe_i(lk.serial_out_oe));
   // Verdict and end of run
   task automatic conclude();
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One host command, write bytes from wq, read bytes into rq
   task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic ae,
                       input logic dm, input logic wr, input int n);
      int k;
      k = 0;
      rq.delete();
      @(negedge clk_i);
      cmd_op    <= op;
      cmd_addr  <= a;
      cmd_ae    <= ae;
      cmd_dm    <= dm;
      cmd_wr    <= wr;
      cmd_n     <= 9'(n);
      wr_byte   <= (wq.size() > 0) ? wq[0] : 8'h00;
      cmd_valid <= 1'b1;
      @(negedge clk_i);
      cmd_valid <= 1'b0;
      while (done !== 1'b1) begin
         @(negedge clk_i);
         if (wr_take === 1'b1) begin
            k++;
            if (k < wq.size()) wr_byte <= wq[k];
         end
         if (rd_valid === 1'b1) rq.push_back(rd_byte);
      end
      chk({7'h0, cmd_ready}, 8'h01);
      wq.delete();
      repeat (4) @(negedge clk_i);
   endtask
   // Status byte over the link
   task automatic stat(input logic [7:0] exp);
      xfer(8'h05, 24'h0, 1'b0, 1'b0, 1'b0, 1);
      chk(rq[0], exp);
   endtask
   // Short one-byte command
   task automatic op1(input logic [7:0] op);
      xfer(op, 24'h0, 1'b0, 1'b0, 1'b0, 0);
   endtask
   // System clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Cycle ceiling
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         conclude();
      end
   end
   // Main sequence
   initial begin
      {arst_n_i, cmd_valid, cmd_ae, cmd_dm, cmd_wr, quad_en} = 6'h00;
      {cmd_op, wr_byte, cmd_addr, cmd_n} = '0;
      lock = 3'h4;
      fails = 0;
      checks_done = 0;
      cyc = 0;
      void'($urandom(32'hfb79));
      repeat (2) @(negedge clk_i);
      arst_n_i = 1'b1;
      chk({4'h0, dummy}, 8'h02);
      chk({1'b0, wrap}, 8'h08);
      // Identification and table reads
      xfer(8'h9f, 24'h0, 1'b0, 1'b0, 1'b0, 3);
      for (int i = 0; i < 3; i++) chk(rq[i], idv[i]);
      xfer(8'h5a, 24'h000002, 1'b1, 1'b1, 1'b0, 2);
      chk(rq[0], 8'h44);
      chk(rq[1], 8'h50);
      xfer(8'h5a, 24'h000102, 1'b1, 1'b1, 1'b0, 1);
      chk(rq[0], 8'hff);
      // Erase register 1, read refused while busy
      op1(8'h06);
      stat(8'h02);
      chk({7'h0, wen}, 8'h01);
      xfer(8'h44, 24'h001000, 1'b1, 1'b0, 1'b0, 0);
      stat(8'h03);
      xfer(8'h48, 24'h001000, 1'b1, 1'b1, 1'b0, 1);
      chk(rq[0], 8'hff);
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk_i);
      chk({7'h0, busy}, 8'h00);
      stat(8'h00);
      chk({7'h0, wen}, 8'h00);
      for (int i = 0; i < 256; i++) mdl[i] = 8'hff;
      // Program across the wrap point, then a refused program
      op1(8'h06);
      for (int i = 0; i < 3; i++) wq.push_back(8'($urandom));
      for (int i = 0; i < 3; i++) mdl[(254 + i) % 256] &= wq[i];
      xfer(8'h42, 24'h0010fe, 1'b1, 1'b0, 1'b1, 3);
      wq.push_back(8'h00);
      xfer(8'h42, 24'h0010fe, 1'b1, 1'b0, 1'b1, 1);
      xfer(8'h48, 24'h0010fe, 1'b1, 1'b1, 1'b0, 4);
      for (int i = 0; i < 4; i++) chk(rq[i], mdl[(254 + i) % 256]);
      // Locked register, bad address, data clocked after address, missing write enable
      op1(8'h06);
      xfer(8'h44, 24'h003000, 1'b1, 1'b0, 1'b0, 0);
      chk({7'h0, busy}, 8'h00);
      xfer(8'h44, 24'h001100, 1'b1, 1'b0, 1'b0, 0);
      chk({7'h0, busy}, 8'h00);
      wq.push_back(8'h00);
      xfer(8'h44, 24'h001000, 1'b1, 1'b0, 1'b1, 1);
      chk({7'h0, busy}, 8'h00);
      op1(8'h04);
      xfer(8'h44, 24'h002000, 1'b1, 1'b0, 1'b0, 0);
      chk({7'h0, busy}, 8'h00);
      // Mode entry and read parameters
      op1(8'h38);
      chk({7'h0, mode4}, 8'h00);
      wq.push_back(8'h33);
      xfer(8'hc0, 24'h0, 1'b0, 1'b0, 1'b1, 1);
      chk({4'h0, dummy}, 8'h02);
      wq.push_back(8'h20);
      xfer(8'h77, 24'h0, 1'b0, 1'b0, 1'b1, 1);
      quad_en = 1'b1;
      op1(8'h38);
      chk({7'h0, mode4}, 8'h01);
      chk({1'b0, wrap}, 8'h20);
      for (int i = 0; i < 4; i++) begin
         wq.push_back({2'h0, 2'(i), 2'h0, 2'(i)});
         xfer(8'hc0, 24'h0, 1'b0, 1'b0, 1'b1, 1);
         chk({4'h0, dummy}, 8'(2 + 2 * i));
         chk({1'b0, wrap}, 8'(8 << i));
      end
      op1(8'hff);
      op1(8'h66);
      op1(8'h99);
      chk({4'h0, dummy}, 8'h02);
      chk({1'b0, wrap}, 8'h08);
      conclude();
   end
endmodule
`default_nettype wire
